/* File: bic_top.sv */
// Design decision made here: the AXI4-Lite interface to the registers.
`default_nettype none
module bic_top
  import bic_pkg::*;
#(
  parameter int ADDR_WIDTH = 10
)(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire bic_event_s            events_in,
  output logic                       irq_out
);

  if (ADDR_WIDTH < 10) begin : g_bad_width
    $error("ADDR_WIDTH must be at least 10");
  end

  bic_event_s            ev_meta_reg;
  bic_event_s            ev_sync_reg;
  bic_event_s            ev_prev_reg;
  logic [7:0]            ctrl_reg;
  logic [7:0]            config_reg;
  logic [7:0]            status_reg;
  logic [7:0]            status_next;
  logic                  irq_reg;
  logic                  aw_hold_reg;
  logic                  w_hold_reg;
  logic [ADDR_WIDTH-1:0] awaddr_reg;
  logic [31:0]           wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic                  rvalid_reg;
  logic [31:0]           rdata_reg;
  logic [1:0]            rresp_reg;
  logic                  wr_fire;
  logic                  status_read;
  logic                  rx_event;
  logic                  ind_event;
  logic                  dn_event;
  logic                  summary;
  logic                  aw_in_range;
  logic                  ar_in_range;
  logic                  aw_mapped;

  // Event inputs come from other logic domains: two-flop synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ev_meta_reg <= '0;
      ev_sync_reg <= '0;
      ev_prev_reg <= '0;
    end
    else
    begin
      ev_meta_reg <= events_in;
      ev_sync_reg <= ev_meta_reg;
      ev_prev_reg <= ev_sync_reg;
    end
  end

  assign ind_event = ev_sync_reg.indirect_done & ~ev_prev_reg.indirect_done;
  assign dn_event  = ev_sync_reg.downstream_irq & ~ev_prev_reg.downstream_irq;
  // Receiver found on presence, or on lock when wait-for-lock is selected
  assign rx_event  = config_reg[WAIT_LOCK_BIT]
                     ? (ev_sync_reg.receiver_lock & ~ev_prev_reg.receiver_lock)
                     : (ev_sync_reg.receiver_present & ~ev_prev_reg.receiver_present);

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign wr_fire       = aw_hold_reg && w_hold_reg && !bvalid_reg;

  // Address bits above the register window must be zero; a shift stays legal when ADDR_WIDTH is 10
  localparam int WINDOW_BITS = 10;
  assign aw_in_range = (awaddr_reg >> WINDOW_BITS) == '0;
  assign ar_in_range = (s_axi_araddr >> WINDOW_BITS) == '0;
  assign aw_mapped   = aw_in_range && (awaddr_reg[9:0] == CTRL_ADDR || awaddr_reg[9:0] == STATUS_ADDR
                       || awaddr_reg[9:0] == CONFIG_ADDR);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // Control and configuration registers; unused control bits held at zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg   <= CTRL_RESET;
      config_reg <= CONFIG_RESET;
    end
    else if (wr_fire && wstrb_reg[0] && aw_in_range)
    begin
      if (awaddr_reg[9:0] == CTRL_ADDR)
        ctrl_reg <= wdata_reg[7:0] & CTRL_MASK;
      if (awaddr_reg[9:0] == CONFIG_ADDR)
        config_reg <= wdata_reg[7:0] & CONFIG_MASK;
    end
  end

  // Read channel
  // Read data is the value before any clear-on-read in the same cycle
  assign s_axi_arready = !rvalid_reg;
  assign status_read   = s_axi_arvalid && s_axi_arready && s_axi_araddr[9:0] == STATUS_ADDR
                         && ar_in_range;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
      if (!ar_in_range)
        rresp_reg <= RESP_SLVERR;
      else if (s_axi_araddr[9:0] == CTRL_ADDR)
        rdata_reg <= {24'h00_0000, ctrl_reg};
      else if (s_axi_araddr[9:0] == STATUS_ADDR)
        rdata_reg <= {24'h00_0000, status_reg};
      else if (s_axi_araddr[9:0] == CONFIG_ADDR)
        rdata_reg <= {24'h00_0000, config_reg};
      else
        rresp_reg <= RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // Sticky source flags, cleared by a status read; a new event wins over the clear
  always_comb
  begin
    status_next = status_reg;
    if (status_read)
      status_next = STATUS_RESET;
    if (ind_event)
      status_next[INDIRECT_BIT] = 1'b1;
    if (rx_event)
      status_next[RECEIVER_BIT] = 1'b1;
    if (dn_event)
      status_next[DOWNSTREAM_BIT] = 1'b1;
    summary = (status_next[INDIRECT_BIT] & ctrl_reg[INDIRECT_BIT])
            | (status_next[RECEIVER_BIT] & ctrl_reg[RECEIVER_BIT])
            | (status_next[DOWNSTREAM_BIT] & ctrl_reg[DOWNSTREAM_BIT]);
    status_next[GLOBAL_BIT] = summary;
    status_next[4:1] = 4'h0;
  end

  // Flags and summary update together on every clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= STATUS_RESET;
    else
      status_reg <= status_next;
  end

  // Registered interrupt line, changing on the same edge as the summary bit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_reg <= 1'b0;
    else
      irq_reg <= ctrl_reg[GLOBAL_BIT] & status_next[GLOBAL_BIT];
  end

  assign irq_out = irq_reg;

  // Interrupt line and flag checks
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_out |-> $past(ctrl_reg[GLOBAL_BIT]))
    else $error("interrupt raised without global enable");

  global_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ctrl_reg[GLOBAL_BIT] |=> !irq_out)
    else $error("interrupt raised while globally disabled");

  irq_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_out == (ctrl_reg[GLOBAL_BIT] & status_reg[GLOBAL_BIT]) || $changed(ctrl_reg))
    else $error("interrupt output disagrees with summary");

  irq_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_read && !ind_event && !rx_event && !dn_event
    |=> !irq_out)
    else $error("interrupt kept after status read");

  summary_ok_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_reg[GLOBAL_BIT] == |(status_reg[7:5] & $past(ctrl_reg[7:5])))
    else $error("summary bit wrong");

  indirect_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ind_event |=> status_reg[INDIRECT_BIT])
    else $error("indirect done flag not set");

  receiver_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_event |=> status_reg[RECEIVER_BIT])
    else $error("receiver found flag not set");

  rx_presence_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !config_reg[WAIT_LOCK_BIT] && ev_sync_reg.receiver_present && !ev_prev_reg.receiver_present
    |=> status_reg[RECEIVER_BIT])
    else $error("receiver presence not flagged");

  downstream_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dn_event |=> status_reg[DOWNSTREAM_BIT])
    else $error("downstream flag not set");

  lock_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(status_reg[RECEIVER_BIT]) && $past(config_reg[WAIT_LOCK_BIT])
    |-> $past(ev_sync_reg.receiver_lock))
    else $error("receiver flag set before lock");

  config_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
    config_reg[7:1] == 7'h00)
    else $error("unused configuration bits not zero");

  unused_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_reg[4:1] == 4'h0 && ctrl_reg[4:1] == 4'h0)
    else $error("unused bits not zero");

  indirect_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_reg[INDIRECT_BIT] && ctrl_reg[INDIRECT_BIT] && ctrl_reg[GLOBAL_BIT]
    && !status_read |=> irq_out)
    else $error("enabled indirect source not forwarded");

  receiver_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_reg[RECEIVER_BIT] && ctrl_reg[RECEIVER_BIT] && ctrl_reg[GLOBAL_BIT]
    && !status_read |=> irq_out)
    else $error("enabled receiver source not forwarded");

  downstream_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_reg[DOWNSTREAM_BIT] && ctrl_reg[DOWNSTREAM_BIT] && ctrl_reg[GLOBAL_BIT]
    && !status_read |=> irq_out)
    else $error("enabled downstream source not forwarded");

  flags_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !status_read |=> &(status_reg[7:5] | ~$past(status_reg[7:5])))
    else $error("source flag lost without status read");

  status_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    status_read && !ind_event && !rx_event && !dn_event
    |=> status_reg == STATUS_RESET)
    else $error("status not cleared by read");

  // Register bus checks
  ctrl_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && wstrb_reg[0] && aw_in_range && awaddr_reg[9:0] == CTRL_ADDR
    |=> ctrl_reg == ($past(wdata_reg[7:0]) & CTRL_MASK))
    else $error("control write not stored");

  strobe_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire && !wstrb_reg[0] |=> $stable(ctrl_reg) && $stable(config_reg))
    else $error("write without byte strobe changed a register");

  write_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid && s_axi_bresp == ($past(aw_mapped) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response missing or wrong");

  bvalid_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");

  read_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");

  read_done_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");

endmodule // bic_top
`default_nettype wire

/* File: bic_pkg.sv */
`default_nettype none
package bic_pkg;
  // Printed offsets 0xC6/0xC7 are not multiples of four: they are register indices
  localparam logic [7:0] CTRL_INDEX   = 8'hC6;
  localparam logic [7:0] STATUS_INDEX = 8'hC7;
  localparam logic [7:0] CONFIG_INDEX = 8'hC8;
  localparam logic [9:0] CTRL_ADDR    = {CTRL_INDEX, 2'b00};
  localparam logic [9:0] STATUS_ADDR  = {STATUS_INDEX, 2'b00};
  localparam logic [9:0] CONFIG_ADDR  = {CONFIG_INDEX, 2'b00};
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam int INDIRECT_BIT = 7;
  localparam int RECEIVER_BIT = 6;
  localparam int DOWNSTREAM_BIT = 5;
  localparam int GLOBAL_BIT = 0;
  localparam int WAIT_LOCK_BIT = 0;
  localparam logic [7:0] CTRL_MASK    = 8'hE1;
  localparam logic [7:0] CONFIG_MASK  = 8'h01;
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

  typedef struct packed {
    logic indirect_done;
    logic receiver_present;
    logic receiver_lock;
    logic downstream_irq;
  } bic_event_s;
endpackage : bic_pkg
`default_nettype wire

/* File: bic_host_model.sv */
`default_nettype none
module bic_host_model
  import bic_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      irq_in,
  output var bic_event_s events_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int   irq_rises = 0;
  logic irq_seen  = 1'b0;
  initial events_out = '0;
  // Host counts each new interrupt assertion
  always @(posedge aclk)
  begin
    irq_seen <= irq_in;
    if (irq_in && !irq_seen)
      irq_rises <= irq_rises + 1;
  end
  // One event level changes; a rising level is the event
  task automatic set_ev(input int i, input logic v);
    logic [3:0] e;
    @(posedge aclk);
    e = events_out;
    e[i] = v;
    events_out <= e;
  endtask
endmodule // bic_host_model
`default_nettype wire

/* File: bridge_interrupt_control_test.sv */
`default_nettype none
module bridge_interrupt_control_test
  import bic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, aresetn = 1'b0, irq;
  logic [9:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic [7:0]  c, seed = 8'h46;
  bic_event_s  ev;
  int          fails = 0, checks_done = 0, nirq = 0, flg;

  bic_top u_bic_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .events_in(ev), .irq_out(irq));
  bic_host_model u_bic_host_model (.aclk(aclk), .irq_in(irq), .events_out(ev));

  initial forever #4 aclk = ~aclk;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Readiness is looked at on the falling edge, where it is settled for the next rising edge
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
    chk(r, er);
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
    chk(d, ed);
    chk(r, er);
  endtask

  task automatic fire(input int i);
    u_bic_host_model.set_ev(i, 1'b1);
    repeat (4) @(posedge aclk);
    u_bic_host_model.set_ev(i, 1'b0);
    repeat (2) @(posedge aclk);
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test();
  end

  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_ADDR, 32'h0, RESP_OKAY);
    rd(STATUS_ADDR, 32'h0, RESP_OKAY);
    wr(CTRL_ADDR, 32'hFFFF_FFFF, RESP_OKAY);
    rd(CTRL_ADDR, 32'hE1, RESP_OKAY);
    wstrb <= 4'hE;
    wr(CTRL_ADDR, 32'h0000_0000, RESP_OKAY);
    wstrb <= 4'hF;
    rd(CTRL_ADDR, 32'hE1, RESP_OKAY);
    wr(10'h3FC, 32'hFF, RESP_SLVERR);
    wr(STATUS_ADDR, 32'hFF, RESP_OKAY);
    rd(STATUS_ADDR, 32'h0, RESP_OKAY);
    rd(10'h3FC, 32'h0, RESP_SLVERR);
    for (int k = 0; k < 14; k++)
    begin
      seed = lfsr(seed);
      c = (k < 6) ? ((8'h80 >> (k % 3)) | 8'(k / 3)) : seed;
      wr(CTRL_ADDR, {24'h0, c}, RESP_OKAY);
      rd(CTRL_ADDR, {24'h0, c & CTRL_MASK}, RESP_OKAY);
      fire((k % 3 == 2) ? 0 : 3 - k % 3);
      flg = 1 << (7 - k % 3);
      q = {24'h0, 8'(flg) | 8'(|(8'(flg) & c & 8'hE0))};
      @(negedge aclk);
      nirq += int'(c[0] && q[0]);
      chk(irq, c[0] & q[0]);
      rd(STATUS_ADDR, q, RESP_OKAY);
      @(negedge aclk);
      chk(irq, 1'b0);
    end
    wr(CONFIG_ADDR, 32'h1, RESP_OKAY);
    rd(CONFIG_ADDR, 32'h1, RESP_OKAY);
    wr(CTRL_ADDR, 32'h41, RESP_OKAY);
    u_bic_host_model.set_ev(2, 1'b1);
    repeat (6) @(posedge aclk);
    rd(STATUS_ADDR, 32'h0, RESP_OKAY);
    fire(1);
    @(negedge aclk);
    nirq++;
    chk(irq, 1'b1);
    rd(STATUS_ADDR, 32'h41, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(u_bic_host_model.irq_rises, nirq);
    u_bic_host_model.set_ev(2, 1'b0);
    u_bic_host_model.set_ev(1, 1'b0);
    wr(CTRL_ADDR, 32'hE1, RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_ADDR, 32'h0, RESP_OKAY);
    rd(CONFIG_ADDR, 32'h0, RESP_OKAY);
    rd(STATUS_ADDR, 32'h0, RESP_OKAY);
    finish_test();
  end
endmodule // bridge_interrupt_control_test
`default_nettype wire
